// file: rtl/bmb_pkg.sv
// Purpose: Shared constants and types of the backplane memory bus interface
// Assumes: 50 MHz clock, one clock domain
// Notes:   Timing counts derive from times given in ns

package bmb_pkg;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int         CLK_NS           = 20;
  localparam int         REF_INTERVAL_NS  = 15600;
  localparam int         REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_NS;
  localparam logic [9:0] REF_RELOAD       = 10'(REF_INTERVAL_CYC - 1);
  localparam int         REF_PULSE_NS     = 60;
  localparam int         REF_PULSE_CYC    = (REF_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] REF_PULSE_LAST   = 2'(REF_PULSE_CYC - 1);

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  localparam logic [7:0]  PPI_FIRST   = 8'hfc;
  localparam logic [7:0]  PPI_LAST    = 8'hff;
  localparam logic [3:0]  SOCK_WIN_HI = 4'h0;
  localparam logic [1:0]  SOCK_SZ_BAD = 2'h3;
  localparam logic [3:0]  SOCK_ONE    = 4'h1;
  localparam logic        ADDR_TOP    = 1'b0;
  localparam logic [19:0] DMA_STEP    = 20'h00001;
  localparam logic [15:0] LEN_STEP    = 16'h0001;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_LATCH, ST_WAIT, ST_XFER, ST_REFR} bmb_st_t;
  typedef enum logic [1:0] {K_CPU, K_DRD, K_DWR} bmb_kind_t;

  typedef struct packed {
    logic [1:0] prev_n;
    logic [1:0] pend;
  } bmb_dreq_st_t;

  typedef struct packed {
    bmb_st_t          st;
    bmb_kind_t        kind;
    logic             ch;
    logic [19:0]      addr;
    logic             io;
    logic             wr;
    logic [7:0]       dout;
    logic             oe;
    logic             sync_n;
    logic             mreq_n;
    logic             iorq_n;
    logic             rd_n;
    logic             wr_n;
    logic             ref_n;
    logic [1:0]       wcnt;
    logic [9:0]       rcnt;
    logic             rpend;
    logic             done;
    logic [7:0]       rdata;
    logic [7:0]       dbuf;
    logic             yld;
    logic [1:0][19:0] dsrc;
    logic [1:0][19:0] ddst;
    logic [1:0][15:0] dlen;
    logic [1:0]       take;
  } bmb_state_t;

endpackage

// file: rtl/bmb_dreq_if.sv
// Purpose: Carries DMA request lines and their detected state
// Assumes: Request lines are active low
// Notes:   take is a one-cycle pulse per channel
`timescale 1ns/10ps

interface bmb_dreq_if;
  logic [1:0] req_n;
  logic [1:0] edge_mode;
  logic [1:0] take;
  logic [1:0] pend;

  modport det (input req_n, input edge_mode, input take, output pend);
  modport eng (output req_n, output edge_mode, output take, input pend);
endinterface

// file: rtl/bmb_dreq.sv
// Purpose: DMA request detection, edge or level per channel
// Assumes: Inputs synchronous to i_clock
// Notes:   An edge arriving with take is kept
`timescale 1ns/10ps

module bmb_dreq (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset,
  // Request carrier
  bmb_dreq_if.det   dq
);

  bmb_pkg::bmb_dreq_st_t s;
  bmb_pkg::bmb_dreq_st_t n;
  logic [1:0]            pend_nxt;

  // --------------------------------------------------------------
  // Per-channel detection
  // --------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign pend_nxt[g] = dq.edge_mode[g] ?
                         ((s.pend[g] && !dq.take[g]) || (s.prev_n[g] && !dq.req_n[g])) :
                         !dq.req_n[g];
  end

  always_comb begin
    n        = s;
    n.prev_n = dq.req_n;
    n.pend   = pend_nxt;
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      s        <= '0;
      s.prev_n <= 2'h3;
    end else begin
      s <= n;
    end
  end

  assign dq.pend = s.pend;

endmodule

// file: rtl/bmb_top.sv
// Purpose: Backplane memory and I/O cycle engine with DMA and refresh
// Assumes: Requests synchronous to i_clock
// Notes:   Upper address nibble shares data lines 3:0
`timescale 1ns/10ps

module bmb_top (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // Processor cycle request
  input  wire logic             i_cpu_req,
  input  wire logic [19:0]      i_cpu_addr,
  input  wire logic             i_cpu_io,
  input  wire logic             i_cpu_wr,
  input  wire logic [7:0]       i_cpu_wdata,
  output logic                  o_cpu_done,
  output logic [7:0]            o_cpu_rdata,
  // Configuration
  input  wire logic [1:0]       i_mem_wait,
  input  wire logic             i_refresh_enable,
  input  wire logic [9:0]       i_io_base,
  input  wire logic [1:0][2:0]  i_sock_base,
  input  wire logic [1:0][1:0]  i_sock_size,
  // DMA
  input  wire logic             i_dma_request_zero_n,
  input  wire logic             i_dma_request_one_n,
  input  wire logic [1:0]       i_dma_edge,
  input  wire logic [1:0]       i_dma_burst,
  input  wire logic [1:0]       i_dma_start,
  input  wire logic [1:0]       i_dma_dst_io,
  input  wire logic [1:0][19:0] i_dma_src,
  input  wire logic [1:0][19:0] i_dma_dst,
  input  wire logic [1:0][15:0] i_dma_len,
  output logic [1:0]            o_dma_busy,
  // Backplane
  output logic [15:0]           o_addr,
  output logic [7:0]            o_data,
  output logic                  o_data_oe,
  input  wire logic [7:0]       i_data,
  output logic                  o_memory_cycle_sync_strobe_n,
  output logic                  o_mreq_n,
  output logic                  o_iorq_n,
  output logic                  o_rd_n,
  output logic                  o_wr_n,
  output logic                  o_refresh_n,
  output logic                  o_memory_expansion_line,
  // Onboard sockets and I/O selects
  output logic [1:0]            o_sock_sel,
  output logic                  o_sock_buf_wr,
  input  wire logic [7:0]       i_sock_rdata,
  output logic                  o_ppi_sel,
  output logic                  o_chip_io_sel
);

  bmb_pkg::bmb_state_t s;
  bmb_pkg::bmb_state_t n;
  logic [1:0]          hit;
  logic [1:0]          active;
  logic [1:0]          elig;
  logic                mem_cyc;
  logic                io_cyc;
  logic [7:0]          rd_val;

  bmb_dreq_if dq ();

  bmb_dreq u_dreq (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .dq      (dq)
  );

  assign dq.req_n     = {i_dma_request_one_n, i_dma_request_zero_n};
  assign dq.edge_mode = i_dma_edge;
  assign dq.take      = s.take;

  // --------------------------------------------------------------
  // Socket and I/O decode
  // --------------------------------------------------------------
  assign mem_cyc = !s.io && s.st != bmb_pkg::ST_IDLE && s.st != bmb_pkg::ST_REFR;
  assign io_cyc  = s.io && s.st != bmb_pkg::ST_IDLE && s.st != bmb_pkg::ST_REFR;

  for (genvar g = 0; g < 2; g++) begin : g_sock
    logic [3:0] off;
    assign off    = {1'b0, s.addr[15:13]} - {1'b0, i_sock_base[g]};
    assign hit[g] = s.addr[19:16] == bmb_pkg::SOCK_WIN_HI
                    && s.addr[15:13] >= i_sock_base[g]
                    && i_sock_size[g] != bmb_pkg::SOCK_SZ_BAD
                    && off < (bmb_pkg::SOCK_ONE << i_sock_size[g]);
    assign active[g] = s.dlen[g] != '0;
  end

  assign o_sock_sel    = hit & {2{mem_cyc}};
  assign o_sock_buf_wr = s.wr;
  assign o_ppi_sel     = io_cyc && s.addr[7:0] >= bmb_pkg::PPI_FIRST
                         && s.addr[7:0] <= bmb_pkg::PPI_LAST;
  assign o_chip_io_sel = io_cyc && s.addr[15:6] == i_io_base;
  assign rd_val        = (|o_sock_sel) ? i_sock_rdata : i_data;
  assign elig          = dq.pend & ~s.take & active;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    n      = s;
    n.done = 1'b0;
    n.take = '0;
    for (int c = 0; c < 2; c++) begin
      if (i_dma_start[c]) begin
        n.dsrc[c] = i_dma_src[c];
        n.ddst[c] = i_dma_dst[c];
        n.dlen[c] = i_dma_len[c];
      end
    end
    unique case (s.st)
      bmb_pkg::ST_IDLE: begin
        if (s.rpend && i_refresh_enable) begin
          n.st    = bmb_pkg::ST_REFR;
          n.rpend = 1'b0;
          n.wcnt  = bmb_pkg::REF_PULSE_LAST;
        end else if (|elig && !(s.yld && i_cpu_req)) begin
          n.ch   = !elig[0];
          n.kind = bmb_pkg::K_DRD;
          n.addr = {bmb_pkg::ADDR_TOP, s.dsrc[!elig[0]][18:0]};
          n.io   = 1'b0;
          n.wr   = 1'b0;
          n.st   = bmb_pkg::ST_ADDR;
        end else if (i_cpu_req && !s.done && !(|(s.take & i_dma_burst & active))) begin
          n.kind = bmb_pkg::K_CPU;
          n.addr = {bmb_pkg::ADDR_TOP, i_cpu_addr[18:0]};
          n.io   = i_cpu_io;
          n.wr   = i_cpu_wr;
          n.dbuf = i_cpu_wdata;
          n.yld  = 1'b0;
          n.st   = bmb_pkg::ST_ADDR;
        end
      end
      bmb_pkg::ST_ADDR: begin
        n.st = bmb_pkg::ST_LATCH;
      end
      bmb_pkg::ST_LATCH: begin
        n.wcnt = s.io ? 2'h0 : i_mem_wait;
        n.st   = (s.io || i_mem_wait == 2'h0) ? bmb_pkg::ST_XFER : bmb_pkg::ST_WAIT;
      end
      bmb_pkg::ST_WAIT: begin
        n.wcnt = s.wcnt - 2'h1;
        if (s.wcnt == 2'h1) begin
          n.st = bmb_pkg::ST_XFER;
        end
      end
      bmb_pkg::ST_XFER: begin
        n.st = bmb_pkg::ST_IDLE;
        unique case (s.kind)
          bmb_pkg::K_CPU: begin
            n.done  = 1'b1;
            n.rdata = rd_val;
          end
          bmb_pkg::K_DRD: begin
            n.dbuf = rd_val;
            n.kind = bmb_pkg::K_DWR;
            n.addr = {bmb_pkg::ADDR_TOP, s.ddst[s.ch][18:0]};
            n.io   = i_dma_dst_io[s.ch];
            n.wr   = 1'b1;
            n.st   = bmb_pkg::ST_ADDR;
          end
          bmb_pkg::K_DWR: begin
            n.dsrc[s.ch] = s.dsrc[s.ch] + bmb_pkg::DMA_STEP;
            if (!s.io) begin
              n.ddst[s.ch] = s.ddst[s.ch] + bmb_pkg::DMA_STEP;
            end
            n.dlen[s.ch] = s.dlen[s.ch] - bmb_pkg::LEN_STEP;
            n.take[s.ch] = 1'b1;
            n.yld        = !i_dma_burst[s.ch];
          end
          default: n.st = bmb_pkg::ST_IDLE;
        endcase
      end
      bmb_pkg::ST_REFR: begin
        if (s.wcnt == 2'h0) begin
          n.st = bmb_pkg::ST_IDLE;
        end else begin
          n.wcnt = s.wcnt - 2'h1;
        end
      end
      default: n.st = bmb_pkg::ST_IDLE;
    endcase
    // Refresh interval timer
    if (s.rcnt == '0) begin
      n.rcnt = bmb_pkg::REF_RELOAD;
      if (i_refresh_enable) begin
        n.rpend = 1'b1;
      end
    end else begin
      n.rcnt = s.rcnt - 10'h001;
    end
    if (!i_refresh_enable) begin
      n.rpend = 1'b0;
    end
    // Pin values follow the next state
    n.sync_n = !(n.st == bmb_pkg::ST_ADDR && !n.io);
    n.mreq_n = !(!n.io && n.st inside {bmb_pkg::ST_ADDR, bmb_pkg::ST_LATCH,
                                       bmb_pkg::ST_WAIT, bmb_pkg::ST_XFER});
    n.iorq_n = !(n.io && n.st inside {bmb_pkg::ST_ADDR, bmb_pkg::ST_LATCH,
                                      bmb_pkg::ST_WAIT, bmb_pkg::ST_XFER});
    n.rd_n   = !(n.st == bmb_pkg::ST_XFER && !n.wr);
    n.wr_n   = !(n.st == bmb_pkg::ST_XFER && n.wr);
    n.ref_n  = !(n.st == bmb_pkg::ST_REFR);
    n.oe     = (n.st == bmb_pkg::ST_ADDR && !n.io)
               || (n.wr && n.st inside {bmb_pkg::ST_WAIT, bmb_pkg::ST_XFER});
    n.dout   = (n.st == bmb_pkg::ST_ADDR) ?
               {4'h0, bmb_pkg::ADDR_TOP, n.addr[18:16]} : n.dbuf;
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      s        <= '0;
      s.sync_n <= 1'b1;
      s.mreq_n <= 1'b1;
      s.iorq_n <= 1'b1;
      s.rd_n   <= 1'b1;
      s.wr_n   <= 1'b1;
      s.ref_n  <= 1'b1;
      s.rcnt   <= bmb_pkg::REF_RELOAD;
    end else begin
      s <= n;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign o_addr                       = s.addr[15:0];
  assign o_data                       = s.dout;
  assign o_data_oe                    = s.oe;
  assign o_memory_cycle_sync_strobe_n = s.sync_n;
  assign o_mreq_n                     = s.mreq_n;
  assign o_iorq_n                     = s.iorq_n;
  assign o_rd_n                       = s.rd_n;
  assign o_wr_n                       = s.wr_n;
  assign o_refresh_n                  = s.ref_n;
  assign o_memory_expansion_line      = 1'b0;
  assign o_cpu_done                   = s.done;
  assign o_cpu_rdata                  = s.rdata;
  assign o_dma_busy                   = active;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  logic [2:0] gap_r;
  logic [1:0] lw_r;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      gap_r <= 3'h0;
      lw_r  <= 2'h0;
    end else begin
      gap_r <= !o_memory_cycle_sync_strobe_n ? 3'h0 : gap_r + 3'h1;
      if (s.st == bmb_pkg::ST_LATCH) begin
        lw_r <= i_mem_wait;
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  nibble_on_data_a: assert property (
    !o_memory_cycle_sync_strobe_n |-> o_data_oe && o_data[2:0] == s.addr[18:16])
    else $error("Upper address nibble not on data lines");

  top_bit_low_a: assert property (
    !o_memory_cycle_sync_strobe_n |-> !o_data[3] && !s.addr[19])
    else $error("Address bit 19 not low");

  memory_expansion_line_low_a: assert property (
    !o_memory_expansion_line)
    else $error("Memory expansion line driven high");

  sync_pulse_a: assert property (
    $fell(o_memory_cycle_sync_strobe_n) |=> o_memory_cycle_sync_strobe_n && !o_mreq_n)
    else $error("Sync strobe did not rise inside the memory cycle");

  addr_stable_a: assert property (
    !o_memory_cycle_sync_strobe_n |=> $stable(o_addr) && $stable(s.addr))
    else $error("Address moved after sync strobe");

  data_release_a: assert property (
    $rose(o_memory_cycle_sync_strobe_n) |-> !o_data_oe)
    else $error("Data lines not released after latch");

  wait_count_a: assert property (
    ($fell(o_rd_n) || $fell(o_wr_n)) && !o_mreq_n |-> gap_r == {1'b0, lw_r} + 3'h1)
    else $error("Wrong number of memory wait states");

  refresh_pulse_a: assert property (
    $fell(o_refresh_n) |-> !o_refresh_n [*3] ##1 o_refresh_n)
    else $error("Refresh strobe length wrong");

  refresh_off_a: assert property (
    $fell(o_refresh_n) |-> $past(i_refresh_enable))
    else $error("Refresh started while disabled");

  ppi_decode_a: assert property (
    o_ppi_sel |-> !o_iorq_n && o_addr[7:2] == 6'h3f)
    else $error("Parallel port select outside its window");

  sock_window_a: assert property (
    |o_sock_sel |-> s.addr[19:16] == 4'h0 && !o_mreq_n)
    else $error("Socket selected above 64K");

  refresh_seen_c: cover property ($fell(o_refresh_n));
  dma_done_c:     cover property ($fell(o_dma_busy[0]));
  slow_write_c:   cover property ($fell(o_wr_n) && lw_r == 2'h3);
  burst_hold_c:   cover property (s.st == bmb_pkg::ST_IDLE && i_cpu_req && |(s.take & i_dma_burst & active));

endmodule

// file: sim/bmb_card.sv
// Purpose: Backplane memory card model
// Assumes: Strobes active low
// Notes:   Read data is a pattern of the address
`timescale 1ns/10ps

module bmb_card (
  // Clock
  input  wire logic        i_clock,
  // Backplane
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_bus,
  input  wire logic        i_sync_n,
  input  wire logic        i_mreq_n,
  input  wire logic        i_iorq_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  output logic [7:0]       o_data
);
  logic [3:0]  hi_r;
  logic [19:0] wa_r;
  logic [7:0]  wd_r;
  logic        wio_r;
  int          wcnt_r;
  logic        sel;

  initial begin
    hi_r = '0;
    wa_r = '0;
    wd_r = '0;
    wio_r = 1'b0;
    wcnt_r = 0;
  end

  assign sel = !(i_mreq_n && i_iorq_n);
  // Released bus shows the inverse of the last write
  assign o_data = (sel && !i_rd_n) ? {i_addr[7:4] ^ hi_r, i_addr[3:0]} : ~wd_r;

  // Upper nibble capture at the clock edge on which the strobe rises
  always @(posedge i_clock) begin
    if (!i_sync_n) hi_r <= i_bus[3:0];
  end

  // Write capture
  always @(posedge i_clock) begin
    if (sel && !i_wr_n) begin
      wa_r <= {hi_r, i_addr};
      wd_r <= i_bus;
      wio_r <= !i_iorq_n;
      wcnt_r <= wcnt_r + 1;
    end
  end
endmodule

// file: sim/test_bmb_top.sv
// Purpose: Self-checking bench of the backplane cycle engine
// Assumes: Card model answers every backplane read
// Notes:   Refresh stays off until its own test
`timescale 1ns/10ps

`define CHK(n, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); \
  end \
end

module test_bmb_top;
  logic             i_clock, i_reset, i_cpu_req, i_cpu_io, i_cpu_wr, i_refresh_enable;
  logic [19:0]      i_cpu_addr;
  logic [7:0]       i_cpu_wdata, i_sock_rdata, o_cpu_rdata, o_data, bus, card_d;
  logic [1:0]       i_mem_wait, i_dma_edge, i_dma_burst, i_dma_start, i_dma_dst_io, o_dma_busy;
  logic [9:0]       i_io_base;
  logic [1:0][2:0]  i_sock_base;
  logic [1:0][1:0]  i_sock_size;
  logic             i_dma_request_zero_n, i_dma_request_one_n;
  logic [1:0][19:0] i_dma_src, i_dma_dst;
  logic [1:0][15:0] i_dma_len;
  logic [15:0]      o_addr, c_addr;
  logic             o_cpu_done, o_data_oe, o_memory_cycle_sync_strobe_n, o_mreq_n, o_iorq_n;
  logic             o_rd_n, o_wr_n, o_refresh_n, o_memory_expansion_line, o_sock_buf_wr;
  logic [1:0]       o_sock_sel, c_sel;
  logic             o_ppi_sel, o_chip_io_sel, c_ppi, c_cio, c_oe, c_bw;
  int               fails, checks, n, k0;

  assign bus = o_data_oe ? o_data : card_d;
  always #10 i_clock = ~i_clock;

  bmb_top u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_cpu_req(i_cpu_req), .i_cpu_addr(i_cpu_addr),
    .i_cpu_io(i_cpu_io), .i_cpu_wr(i_cpu_wr), .i_cpu_wdata(i_cpu_wdata), .o_cpu_done(o_cpu_done),
    .o_cpu_rdata(o_cpu_rdata), .i_mem_wait(i_mem_wait), .i_refresh_enable(i_refresh_enable),
    .i_io_base(i_io_base), .i_sock_base(i_sock_base), .i_sock_size(i_sock_size),
    .i_dma_request_zero_n(i_dma_request_zero_n), .i_dma_request_one_n(i_dma_request_one_n),
    .i_dma_edge(i_dma_edge), .i_dma_burst(i_dma_burst), .i_dma_start(i_dma_start),
    .i_dma_dst_io(i_dma_dst_io), .i_dma_src(i_dma_src), .i_dma_dst(i_dma_dst), .i_dma_len(i_dma_len),
    .o_dma_busy(o_dma_busy), .o_addr(o_addr), .o_data(o_data), .o_data_oe(o_data_oe), .i_data(bus),
    .o_memory_cycle_sync_strobe_n(o_memory_cycle_sync_strobe_n), .o_mreq_n(o_mreq_n),
    .o_iorq_n(o_iorq_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_refresh_n(o_refresh_n),
    .o_memory_expansion_line(o_memory_expansion_line), .o_sock_sel(o_sock_sel),
    .o_sock_buf_wr(o_sock_buf_wr), .i_sock_rdata(i_sock_rdata), .o_ppi_sel(o_ppi_sel),
    .o_chip_io_sel(o_chip_io_sel));

  bmb_card u_card (.i_clock(i_clock), .i_addr(o_addr), .i_bus(bus), .i_sync_n(o_memory_cycle_sync_strobe_n),
    .i_mreq_n(o_mreq_n), .i_iorq_n(o_iorq_n), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .o_data(card_d));

  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] ^ {a[19:16], 4'h0};
  endfunction

  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask

  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // Processor cycle with capture of the strobed outputs
  // -------------------------------------------------------------
  task automatic cpu(input logic [19:0] a, input logic io, input logic wr, input logic [7:0] wd);
    logic ps;
    tick;
    ps = 1'b1;
    n = 0;
    {c_sel, c_ppi, c_cio, c_bw, c_addr} = '0;
    c_oe = 1'b1;
    {i_cpu_addr, i_cpu_io, i_cpu_wr, i_cpu_wdata} = {a, io, wr, wd};
    i_cpu_req = 1'b1;
    while (o_cpu_done !== 1'b1 && n < 40) begin
      tick;
      n++;
      if (!o_mreq_n || !o_iorq_n) begin
        c_sel |= o_sock_sel;
        c_ppi |= o_ppi_sel;
        c_cio |= o_chip_io_sel;
        c_bw |= (o_sock_sel != 2'h0) && o_sock_buf_wr;
      end
      if (!o_memory_cycle_sync_strobe_n) c_addr = o_addr;
      if (!ps && o_memory_cycle_sync_strobe_n) c_oe = o_data_oe;
      ps = o_memory_cycle_sync_strobe_n;
    end
    i_cpu_req = 1'b0;
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_read;
    `CHK("sync idle", 1'b1, o_memory_cycle_sync_strobe_n)
    `CHK("oe idle", 1'b0, o_data_oe)
    `CHK("dma idle", 2'h0, o_dma_busy)
    for (int w = 0; w < 4; w++) begin
      i_mem_wait = 2'(w);
      cpu(20'hfa5c3, 1'b0, 1'b0, 8'h00);
      `CHK("mem cycles", 4 + w, n)
      `CHK("low addr", 16'ha5c3, c_addr)
      `CHK("latched hi", 4'h7, u_card.hi_r)
      `CHK("read data", pat(20'h7a5c3), o_cpu_rdata)
      `CHK("released", 1'b0, c_oe)
    end
    i_mem_wait = 2'h2;
    cpu(20'h31234, 1'b0, 1'b1, 8'hc3);
    `CHK("write cycles", 6, n)
    `CHK("write addr", 20'h31234, u_card.wa_r)
    `CHK("write data", 8'hc3, u_card.wd_r)
    $display("test read write done");
  endtask

  task automatic t_decode;
    logic [19:0] a [11] = '{20'h000fc, 20'h000ff, 20'h000fb, 20'h00040, 20'h0003f,
                            20'h04000, 20'h06000, 20'h0a000, 20'h0dfff, 20'h0e000, 20'h1a000};
    logic [1:0]  e [11] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0};
    i_mem_wait = 2'h3;
    i_io_base = 10'h001;
    i_sock_base = {3'h5, 3'h2};
    i_sock_size = {2'h1, 2'h0};
    for (int k = 0; k < 11; k++) begin
      cpu(a[k], k < 5, 1'b0, 8'h00);
      if (k < 5) begin
        `CHK("io cycles", 4, n)
        `CHK("ppi select", e[k][1], c_ppi)
        `CHK("chip select", e[k][0], c_cio)
      end else begin
        `CHK("socket select", e[k], c_sel)
        if (e[k] != 2'h0) `CHK("socket data", 8'h96, o_cpu_rdata)
      end
    end
    cpu(20'h05000, 1'b0, 1'b1, 8'h3c);
    `CHK("socket write dir", 1'b1, c_bw)
    i_sock_size = {2'h3, 2'h3};
    $display("test decode done");
  endtask

  task automatic t_dma;
    i_mem_wait = 2'h1;
    i_dma_src = {20'h20010, 20'h12340};
    i_dma_dst = {20'h000f0, 20'h05670};
    i_dma_len = {16'h0002, 16'h0002};
    k0 = u_card.wcnt_r;
    i_dma_start = 2'h3;
    tick;
    i_dma_start = 2'h0;
    tick;
    `CHK("dma busy", 2'h3, o_dma_busy)
    i_dma_request_zero_n = 1'b0;
    for (int k = 0; k < 100 && o_dma_busy[0]; k++) tick;
    i_dma_request_zero_n = 1'b1;
    `CHK("level count", 2, u_card.wcnt_r - k0)
    `CHK("mem dst", 20'h05671, u_card.wa_r)
    `CHK("mem data", pat(20'h12341), u_card.wd_r)
    for (int p = 0; p < 2; p++) begin
      k0 = u_card.wcnt_r;
      i_dma_request_one_n = 1'b0;
      repeat (40) tick;
      i_dma_request_one_n = 1'b1;
      tick;
      `CHK("edge count", 1, u_card.wcnt_r - k0)
      `CHK("io dst", 1'b1, u_card.wio_r)
      `CHK("io addr", 16'h00f0, u_card.wa_r[15:0])
      `CHK("edge busy", p == 0, o_dma_busy[1])
    end
    `CHK("io data", pat(20'h20011), u_card.wd_r)
    $display("test dma done");
  endtask

  task automatic t_steal;
    for (int m = 0; m < 2; m++) begin
      i_dma_burst = 2'(m);
      i_dma_len[0] = 16'h0002;
      i_dma_start = 2'h1;
      tick;
      i_dma_start = 2'h0;
      cpu(20'h00200, 1'b0, 1'b0, 8'h00);
      k0 = u_card.wcnt_r;
      i_dma_request_zero_n = 1'b0;
      cpu(20'h00300, 1'b0, 1'b0, 8'h00);
      `CHK("dma before cpu", 1 + m, u_card.wcnt_r - k0)
      for (int k = 0; k < 100 && o_dma_busy[0]; k++) tick;
      i_dma_request_zero_n = 1'b1;
      `CHK("dma total", 2, u_card.wcnt_r - k0)
    end
    $display("test steal burst done");
  endtask

  task automatic t_refresh;
    int lo;
    i_refresh_enable = 1'b1;
    for (int k = 0; k < 1000 && o_refresh_n !== 1'b0; k++) tick;
    lo = 0;
    while (o_refresh_n === 1'b0 && lo < 10) begin
      `CHK("no mreq", 1'b1, o_mreq_n)
      lo++;
      tick;
    end
    `CHK("refresh width", 3, lo)
    `CHK("expansion", 1'b0, o_memory_expansion_line)
    i_refresh_enable = 1'b0;
    lo = 0;
    repeat (1000) begin
      tick;
      if (o_refresh_n !== 1'b1) lo++;
    end
    `CHK("refresh off", 0, lo)
    $display("test refresh done");
  endtask

  initial begin
    {i_clock, i_cpu_req, i_cpu_io, i_cpu_wr, i_refresh_enable} = '0;
    {i_cpu_addr, i_cpu_wdata, i_mem_wait, i_io_base, i_dma_start} = '0;
    {i_dma_src, i_dma_dst, i_dma_len} = '0;
    {i_dma_edge, i_dma_burst, i_dma_dst_io} = {2'h2, 2'h1, 2'h2};
    {i_dma_request_zero_n, i_dma_request_one_n} = 2'h3;
    i_sock_base = '0;
    i_sock_size = {2'h3, 2'h3};
    i_sock_rdata = 8'h96;
    i_reset = 1'b1;
    fails = 0;
    checks = 0;
    repeat (5) @(posedge i_clock);
    #1 i_reset = 1'b0;
    t_read;
    t_decode;
    t_dma;
    t_steal;
    t_refresh;
    complete_run;
  end

  initial begin
    #(8000 * 20);
    fails++;
    complete_run;
  end
endmodule
